// *** src/uil_defs.vh ***
// register map, field layout and reset values of the uart interrupt level/mask block
`ifndef UIL_DEFS_VH
`define UIL_DEFS_VH
`define UIL_OFF_TRIG 12'h034
`define UIL_OFF_MASK 12'h038
`define UIL_OFF_RAW 12'h03C
`define UIL_OFF_MIS 12'h040
`define UIL_OFF_CLR 12'h044
`define UIL_OFF_LVL 12'h048
`define UIL_TX_SEL_LSB 0
`define UIL_TX_SEL_MSB 2
`define UIL_RX_SEL_LSB 3
`define UIL_RX_SEL_MSB 5
`define UIL_SEL_RST 3'h2
`define UIL_SEL_3Q 3'h6
`define UIL_MASK_RST 13'h0000
`define UIL_SRC_BITS 13'h1FF2
`define UIL_BIT_CTS 1
`define UIL_BIT_RX 4
`define UIL_BIT_TX 5
`define UIL_BIT_RT 6
`define UIL_BIT_FE 7
`define UIL_BIT_PE 8
`define UIL_BIT_BE 9
`define UIL_BIT_OE 10
`define UIL_BIT_XOFF 11
`define UIL_BIT_TXFE 12
`define UIL_FIFO_DEPTH 7'h40
`endif

// *** src/uil_threshold.v ***
// fifo trigger-level comparator: level vs fraction of a 64-entry fifo
`timescale 1ns/10ps
`default_nettype none
`include "uil_defs.vh"
module uil_threshold (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // selection and level
  input wire [2:0] sel,
  input wire [6:0] level,
  // registered result
  output reg hit_ff
);
  function [6:0] thrOf;
    input [2:0] s;
    begin
      case (s)
        3'h0: thrOf = 7'h01;
        3'h1: thrOf = 7'h02;
        3'h2: thrOf = 7'h04;
        3'h3: thrOf = 7'h08;
        3'h4: thrOf = 7'h10;
        3'h5: thrOf = 7'h20;
        default: thrOf = 7'h30;
      endcase
    end
  endfunction
  wire nxt_hit;
  assign nxt_hit = (level >= thrOf(sel));
  always @(posedge clk_sys) begin
    if (rst) begin
      hit_ff <= 1'b0;
    end else begin
      hit_ff <= nxt_hit;
    end
  end
endmodule
`default_nettype wire

// *** src/uil_irq_status.v ***
// sticky raw status with write-one-to-clear; set beats clear
`timescale 1ns/10ps
`default_nettype none
`include "uil_defs.vh"
module uil_irq_status (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // events and clears
  input wire [12:0] setBits,
  input wire [12:0] clrBits,
  // sticky status
  output reg [12:0] raw_ff
);
  wire [12:0] nxt_raw;
  assign nxt_raw = ((raw_ff & ~clrBits) | setBits) & `UIL_SRC_BITS;
  always @(posedge clk_sys) begin
    if (rst) begin
      raw_ff <= 13'h0000;
    end else begin
      raw_ff <= nxt_raw;
    end
  end
endmodule
`default_nettype wire

// *** src/uil_top.v ***
// uart interrupt trigger level and mask block with apb slave
// Functional notes
// - tx trigger field bits 2:0 picks empty fraction 1/64..3/4, resets 2
// - rx trigger field bits 5:3 picks fill fraction 1/64..3/4, resets 2
// - mask bit 1 enables the cts change interrupt
// - mask bit 4 enables the receive interrupt
// - mask bit 5 enables the transmit interrupt
// - mask bit 6 enables the receive timeout interrupt
// - mask bit 7 enables the framing error interrupt
// - mask bit 8 enables the parity error interrupt
// - mask bit 9 enables the break error interrupt
// - mask bit 10 enables the overrun error interrupt
// - mask bit 11 enables the xoff interrupt
// - mask bit 12 enables the tx fifo empty interrupt
// - mask register reads back as last written, with reserved bits 0, 2, 3 and 31:13 reading zero
// - all mask bits are zero after reset
// - masked status equals pending raw status and mask
// - writing one to a clear bit removes the pending interrupt unless that source fires in the same cycle
`timescale 1ns/10ps
`default_nettype none
`include "uil_defs.vh"
module uil_top (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata_ff,
  output reg pready_ff,
  output reg pslverr_ff,
  // raw event pulses from the uart core
  input wire evCtsChange,
  input wire evRxTimeout,
  input wire evFramingErr,
  input wire evParityErr,
  input wire evBreakErr,
  input wire evOverrunErr,
  input wire evFlowStop,
  input wire evTxEmpty,
  // fifo occupancy, 0..64 entries
  input wire [6:0] rxLevel,
  input wire [6:0] txLevel,
  // trigger selects to the uart core
  output reg [2:0] txTriggerSelect_ff,
  output reg [2:0] rxTriggerSelect_ff,
  // combined interrupt
  output reg irq_ff
);
  reg [12:0] maskEn_ff;
  reg [12:0] nxt_mask;
  reg [2:0] nxt_txSel;
  reg [2:0] nxt_rxSel;
  reg [12:0] clrReq;
  reg [31:0] nxt_rdata;
  reg nxt_err;
  reg rxHitD_ff;
  reg txHitD_ff;
  wire rxHit;
  wire txHit;
  wire [12:0] rawSt;
  wire [12:0] misSt;
  wire [12:0] evSet;
  wire [6:0] txEmpty;
  wire setupAcc;
  wire wrAcc;

  // one wait-free access phase; answer registered at end of setup
  assign setupAcc = psel & ~penable;
  // write lands only at the edge where the master sees pready
  assign wrAcc = psel & penable & pready_ff & pwrite;

  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `UIL_OFF_TRIG) || (a == `UIL_OFF_MASK) ||
        (a == `UIL_OFF_RAW) || (a == `UIL_OFF_MIS) ||
        (a == `UIL_OFF_CLR) || (a == `UIL_OFF_LVL);
    end
  endfunction

  // tx threshold compare on empty space
  assign txEmpty = `UIL_FIFO_DEPTH - txLevel;
  uil_threshold txCmp (
    .clk_sys(clk_sys),
    .rst(rst),
    .sel(txTriggerSelect_ff),
    .level(txEmpty),
    .hit_ff(txHit)
  );
  uil_threshold rxCmp (
    .clk_sys(clk_sys),
    .rst(rst),
    .sel(rxTriggerSelect_ff),
    .level(rxLevel),
    .hit_ff(rxHit)
  );

  // fifo interrupts fire on crossing into the threshold, so a clear sticks
  assign evSet = {evTxEmpty, evFlowStop, evOverrunErr, evBreakErr, evParityErr,
    evFramingErr, evRxTimeout, txHit & ~txHitD_ff, rxHit & ~rxHitD_ff,
    2'b00, evCtsChange, 1'b0};

  uil_irq_status stat (
    .clk_sys(clk_sys),
    .rst(rst),
    .setBits(evSet),
    .clrBits(clrReq),
    .raw_ff(rawSt)
  );

  assign misSt = rawSt & maskEn_ff;

  // register writes
  always @* begin
    nxt_mask = maskEn_ff;
    nxt_txSel = txTriggerSelect_ff;
    nxt_rxSel = rxTriggerSelect_ff;
    clrReq = 13'h0000;
    if (wrAcc && paddr == `UIL_OFF_TRIG && pstrb[0]) begin
      nxt_txSel = pwdata[`UIL_TX_SEL_MSB:`UIL_TX_SEL_LSB];
      nxt_rxSel = pwdata[`UIL_RX_SEL_MSB:`UIL_RX_SEL_LSB];
    end
    if (wrAcc && paddr == `UIL_OFF_MASK) begin
      if (pstrb[0]) begin
        nxt_mask[7:0] = {pwdata[7:4], 2'b00, pwdata[1], 1'b0};
      end
      if (pstrb[1]) begin
        nxt_mask[12:8] = pwdata[12:8];
      end
    end
    if (wrAcc && paddr == `UIL_OFF_CLR) begin
      clrReq = {pstrb[1] ? pwdata[12:8] : 5'h00,
        pstrb[0] ? pwdata[7:0] : 8'h00} & `UIL_SRC_BITS;
    end
  end

  // read mux; reserved bits zero
  always @* begin
    nxt_rdata = 32'h00000000;
    nxt_err = 1'b0;
    case (paddr)
      `UIL_OFF_TRIG: nxt_rdata = {26'h0000000, rxTriggerSelect_ff, txTriggerSelect_ff};
      `UIL_OFF_MASK: nxt_rdata = {19'h00000, maskEn_ff};
      `UIL_OFF_RAW: nxt_rdata = {19'h00000, rawSt};
      `UIL_OFF_MIS: nxt_rdata = {19'h00000, misSt};
      `UIL_OFF_CLR: nxt_rdata = 32'h00000000;
      `UIL_OFF_LVL: nxt_rdata = {18'h00000, txLevel, rxLevel};
      default: nxt_err = 1'b1;
    endcase
    if (!mapped(paddr)) begin
      nxt_err = 1'b1;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      maskEn_ff <= `UIL_MASK_RST;
      txTriggerSelect_ff <= `UIL_SEL_RST;
      rxTriggerSelect_ff <= `UIL_SEL_RST;
      prdata_ff <= 32'h00000000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      irq_ff <= 1'b0;
      rxHitD_ff <= 1'b0;
      txHitD_ff <= 1'b0;
    end else begin
      maskEn_ff <= nxt_mask;
      txTriggerSelect_ff <= nxt_txSel;
      rxTriggerSelect_ff <= nxt_rxSel;
      pready_ff <= setupAcc;
      pslverr_ff <= setupAcc & nxt_err;
      prdata_ff <= (setupAcc && !pwrite) ? nxt_rdata : 32'h00000000;
      // combined interrupt is or of masked status
      irq_ff <= |misSt;
      rxHitD_ff <= rxHit;
      txHitD_ff <= txHit;
    end
  end
endmodule
`default_nettype wire

// *** verif/uil_top_chk.sv ***
// assertions on the apb slave, trigger selects and masked interrupt
`timescale 1ns/10ps
`default_nettype none
module uil_top_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata_ff,
  input wire logic pready_ff,
  // interrupt side
  input wire logic evCtsChange,
  input wire logic [2:0] txTriggerSelect_ff,
  input wire logic [2:0] rxTriggerSelect_ff,
  input wire logic irq_ff
);
  logic [12:0] mask_ff;
  wire setup = psel && !penable;
  wire access = psel && penable && pready_ff;
  wire [5:0] trigIn = pwdata[5:0];
  wire [5:0] selOut = {rxTriggerSelect_ff, txTriggerSelect_ff};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // shadow tracks writes with both low byte strobes set only; reserved bits never stick
  always_ff @(posedge clk_sys) begin
    if (rst)
      mask_ff <= 13'h0000;
    else if (access && pwrite && paddr == 12'h038 && pstrb[1:0] == 2'h3)
      mask_ff <= pwdata[12:0] & 13'h1FF2;
  end
  a_ready_next: assert property (setup |=> pready_ff) else $error("no ready after setup");
  a_ready_pulse: assert property (pready_ff |=> !pready_ff) else $error("ready held");
  a_data_idle: assert property (!pready_ff |-> prdata_ff == 32'h0)
    else $error("read data outside access");
  a_sel_reset: assert property ($past(rst) |-> selOut == 6'h12)
    else $error("trigger select reset value");
  a_trig_write: assert property (access && pwrite && paddr == 12'h034 && pstrb[0]
    |=> selOut == $past(trigIn)) else $error("trigger select not written");
  a_mask_read: assert property (setup && !pwrite && paddr == 12'h038
    |=> prdata_ff == {19'h0, mask_ff}) else $error("mask readback");
  a_irq_masked: assert property ($past(mask_ff) == 13'h0000 |-> !irq_ff)
    else $error("irq with all sources masked");
  a_cts_enable: assert property (evCtsChange && mask_ff[1] |-> ##2 irq_ff)
    else $error("enabled cts change gave no irq");
endmodule
bind uil_top uil_top_chk CHK (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .prdata_ff, .pready_ff, .evCtsChange, .txTriggerSelect_ff, .rxTriggerSelect_ff, .irq_ff);
`default_nettype wire

// *** verif/uil_far_model.sv ***
// uart core model: event pulses and fifo occupancy
`timescale 1ns/10ps
`default_nettype none
module uil_far_model (
  // clock
  input wire logic clk_sys,
  // bench requests
  input wire logic [7:0] evReq,
  input wire logic [6:0] rxReq,
  input wire logic [6:0] txReq,
  // to the block
  output logic [7:0] ev_ff,
  output logic [6:0] rxLevel_ff,
  output logic [6:0] txLevel_ff
);
  // launched just after the edge, like the core flops
  always_ff @(posedge clk_sys) begin
    ev_ff <= evReq;
    rxLevel_ff <= rxReq;
    txLevel_ff <= txReq;
  end
endmodule
`default_nettype wire

// *** verif/test_uart_irq_level_and_mask.sv ***
// self-checking bench for the uart trigger level and mask block
`timescale 1ns/10ps
`default_nettype none
module test_uart_irq_level_and_mask;
  typedef struct {logic [12:0] mask; int src; logic irq;} uil_row_t;
  logic clk_sys = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0] pstrb = 4'h0;
  logic [7:0] evReq = 8'h0, ev;
  logic [6:0] rxReq = 7'h0, txReq = 7'h40, rxLevel, txLevel;
  wire [31:0] prdata_ff;
  wire pready_ff, pslverr_ff, irq_ff;
  wire [2:0] txSel, rxSel;
  int fails = 0, checks_done = 0, i;
  int srcBit[8] = '{1, 6, 7, 8, 9, 10, 11, 12};
  uil_row_t rows[16];
  always #2 clk_sys = ~clk_sys;
  uil_top DUT (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata_ff,
    .pready_ff, .pslverr_ff, .evCtsChange(ev[0]), .evRxTimeout(ev[1]), .evFramingErr(ev[2]),
    .evParityErr(ev[3]), .evBreakErr(ev[4]), .evOverrunErr(ev[5]), .evFlowStop(ev[6]),
    .evTxEmpty(ev[7]), .rxLevel, .txLevel, .txTriggerSelect_ff(txSel),
    .rxTriggerSelect_ff(rxSel), .irq_ff);
  uil_far_model FAR (.clk_sys, .evReq, .rxReq, .txReq, .ev_ff(ev), .rxLevel_ff(rxLevel),
    .txLevel_ff(txLevel));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge clk_sys);
    penable <= 1'h1;
    do @(posedge clk_sys); while (pready_ff !== 1'h1);
    rd = prdata_ff;
    err = pslverr_ff;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #20000;
    fails++;
    test_done;
  end
  initial begin
    for (i = 0; i < 8; i++) begin
      rows[2 * i] = '{13'h1 << srcBit[i], i, 1'h1};
      rows[2 * i + 1] = '{13'h1FF2 ^ (13'h1 << srcBit[i]), i, 1'h0};
    end
    repeat (12) @(posedge clk_sys);
    rst <= 1'h0;
    rdc(12'h034, 32'h12);
    rdc(12'h038, 32'h0);
    $display("reset test done");
    apb(1'h1, 12'h044, 32'h1FF2);
    for (i = 0; i < 16; i++) begin
      apb(1'h1, 12'h038, {19'h0, rows[i].mask});
      evReq <= 8'h1 << rows[i].src;
      @(posedge clk_sys);
      evReq <= 8'h0;
      repeat (3) @(posedge clk_sys);
      chk({31'h0, irq_ff}, {31'h0, rows[i].irq});
      rdc(12'h040, rows[i].irq ? 32'h1 << srcBit[rows[i].src] : 32'h0);
      apb(1'h1, 12'h044, 32'h1FF2);
      rdc(12'h03C, 32'h0);
    end
    $display("mask table test done");
    apb(1'h1, 12'h038, 32'hFFFFFFFF);
    rdc(12'h038, 32'h1FF2);
    apb(1'h0, 12'h050, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (i = 0; i < 7; i++) begin
      apb(1'h1, 12'h034, 32'(i * 9));
      @(posedge clk_sys);
      chk({26'h0, rxSel, txSel}, 32'(i * 9));
    end
    // rx fires at one entry, tx only at 48 free of 64
    apb(1'h1, 12'h034, 32'h06);
    apb(1'h1, 12'h038, 32'h30);
    apb(1'h1, 12'h044, 32'h1FF2);
    rxReq <= 7'h01;
    txReq <= 7'h11;
    repeat (4) @(posedge clk_sys);
    rdc(12'h03C, 32'h10);
    txReq <= 7'h10;
    repeat (4) @(posedge clk_sys);
    rdc(12'h03C, 32'h30);
    chk({31'h0, irq_ff}, 32'h1);
    apb(1'h1, 12'h034, 32'h3F);
    @(posedge clk_sys);
    chk({26'h0, rxSel, txSel}, 32'h3F);
    txReq <= 7'h11;
    repeat (4) @(posedge clk_sys);
    apb(1'h1, 12'h044, 32'h1FF2);
    rxReq <= 7'h30;
    repeat (4) @(posedge clk_sys);
    rdc(12'h03C, 32'h10);
    $display("fifo trigger test done");
    test_done;
  end
endmodule
`default_nettype wire
